// ### verilog/adc_clock_tree_pkg.sv
// Package: register map, field layout, clock tree encodings and types
package adc_clock_tree_pkg;

    localparam logic [7:0] POWER_AND_MODULATOR_CLOCK_CONTROL_OFFSET = 8'h04;
    localparam logic [7:0] DATA_CLOCK_CONTROL_OFFSET                = 8'h07;
    localparam logic [7:0] CLOCK_TREE_STATUS_OFFSET                 = 8'h08;

    // Field positions
    localparam int POWER_MODE_LSB     = 4;
    localparam int MOD_DIV_LSB        = 0;
    localparam int DATA_CLOCK_DIVIDER_LSB       = 0;
    localparam int STRAP_POWER_LSB    = 0;
    localparam int STRAP_DATA_CLOCK_DIVIDER_LSB = 2;
    localparam int STATUS_SOURCE_LSB  = 6;

    // Values after reset
    localparam logic [7:0] POWER_AND_MODULATOR_CLOCK_CONTROL_RESET = 8'h00;
    localparam logic [7:0] DATA_CLOCK_CONTROL_RESET                = 8'h00;

    // Divide ratios in master clock cycles
    localparam logic [5:0] MOD_RATIO_FAST   = 6'h04;
    localparam logic [5:0] MOD_RATIO_MEDIAN = 6'h08;
    localparam logic [5:0] MOD_RATIO_LOW    = 6'h20;
    localparam logic [5:0] DATA_OUTPUT_CLOCK_RATIO_1     = 6'h01;
    localparam logic [5:0] DATA_OUTPUT_CLOCK_RATIO_2     = 6'h02;
    localparam logic [5:0] DATA_OUTPUT_CLOCK_RATIO_4     = 6'h04;
    localparam logic [5:0] DATA_OUTPUT_CLOCK_RATIO_8     = 6'h08;

    // Samples taken per modulator clock period
    localparam int SAMPLES_PER_MOD_PERIOD = 2;

    typedef enum logic [1:0] {
        POWER_LOW    = 2'h0,
        POWER_MEDIAN = 2'h1,
        POWER_FAST   = 2'h2,
        POWER_RSVD   = 2'h3
    } power_mode_e;

    typedef enum logic [1:0] {
        MOD_DIV_32 = 2'h0,
        MOD_DIV_8  = 2'h1,
        MOD_DIV_4  = 2'h2,
        MOD_DIV_RSVD = 2'h3
    } mod_div_e;

    typedef enum logic [1:0] {
        SRC_CMOS    = 2'h0,
        SRC_CRYSTAL = 2'h1,
        SRC_LVDS    = 2'h2,
        SRC_RSVD    = 2'h3
    } clk_source_e;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        power_mode_e power_mode;
        mod_div_e    mod_div;
        logic [1:0]  data_clock_divider;
    } clock_setting_s;

    typedef struct packed {
        logic mod_clk;
        logic mod_clk_rise;
        logic sample_en;
        logic data_output_clock;
        logic data_output_clock_rise;
    } clock_out_s;

endpackage

// ### verilog/glitchless_divider.sv
// Glitch-free divider: new ratio is loaded only at the end of a whole period
`timescale 1ns/100ps
module glitchless_divider (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic [5:0] i_ratio,
    output logic            o_tick,
    output logic            o_half_tick,
    output logic            o_level
);
    logic [5:0] period;
    logic [5:0] count;
    logic [5:0] half;
    logic       at_end;
    logic [5:0] next_count;
    logic [5:0] next_period;
    logic       next_level;

    assign half        = {1'b0, period[5:1]};
    assign at_end      = (count == 6'h00);
    // Ratio switches only at a period boundary so no runt pulse appears
    assign next_period = at_end ? i_ratio : period;
    assign next_count  = at_end ? (i_ratio - 6'h01) : (count - 6'h01);
    assign next_level  = (next_period == 6'h01) ? 1'b1 : (next_count >= {1'b0, next_period[5:1]});

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            period  <= 6'h01;
            count   <= 6'h00;
            o_level <= 1'b0;
        end else begin
            period  <= next_period;
            count   <= next_count;
            o_level <= next_level;
        end
    end

    assign o_tick      = at_end;
    assign o_half_tick = (period != 6'h01) && (count == half);
endmodule

// ### verilog/adc_clock_tree_power_scaling.sv
// Clock tree and power scaling control of a multichannel sigma-delta converter
// What this block does
// - Master clock comes from one of three sources: logic, crystal or differential.
// - All cores share the master clock; modulators sample at twice modulator rate.
// - Data output clock is also derived from the master clock.
// - Modulator clock and data output clock stay synchronous to master clock.
// - Modulator divider offers master clock divided by 4, 8 or 32 only.
// - Divider and power mode apply identically to all channels.
// - Serial control programs power, modulator divider and data clock via 0x04, 0x07.
// - Under serial control power mode and modulator divider are independent.
// - Under strap control the mode straps set power, modulator and data clock rates.
// - Strap control ties divider to power: 32 low, 8 median, 4 fast.
// - Divider versus decimation balancing is possible only under serial control.
// - Data output clock divider selects master clock divided by 1, 2, 4 or 8.
// - Data output clock runs continuously, never gated to transfers.
`timescale 1ns/100ps
module adc_clock_tree_power_scaling (
    input  wire logic                              i_core_clk,
    input  wire logic                              i_rst_n,
    input  wire logic                              i_serial_control,
    input  wire logic [3:0]                        i_mode_strap_pins,
    input  wire logic [1:0]                        i_clk_source_strap,
    input  wire adc_clock_tree_pkg::reg_req_s      i_reg_req,
    output logic [7:0]                             o_reg_rdata,
    output adc_clock_tree_pkg::clock_setting_s     o_setting,
    output adc_clock_tree_pkg::clk_source_e        o_clk_source,
    output logic [2:0]                             o_clk_source_onehot,
    output adc_clock_tree_pkg::clock_out_s         o_clocks
);
    import adc_clock_tree_pkg::*;

    function automatic logic [5:0] mod_ratio(input mod_div_e code);
        unique case (code)
            MOD_DIV_8:  mod_ratio = MOD_RATIO_MEDIAN;
            MOD_DIV_4:  mod_ratio = MOD_RATIO_FAST;
            default:    mod_ratio = MOD_RATIO_LOW;
        endcase
    endfunction

    function automatic mod_div_e div_for_power(input power_mode_e mode);
        unique case (mode)
            POWER_LOW:    div_for_power = MOD_DIV_32;
            POWER_MEDIAN: div_for_power = MOD_DIV_8;
            default:      div_for_power = MOD_DIV_4;
        endcase
    endfunction

    function automatic power_mode_e strap_power(input logic [1:0] code);
        unique case (code)
            2'h0:       strap_power = POWER_LOW;
            2'h1:       strap_power = POWER_MEDIAN;
            2'h2, 2'h3: strap_power = POWER_FAST;   // Code 3 doubles as fast; reserved power reaches the cores only through register 0x04 under serial control
        endcase
    endfunction

    // Data clock ratio per code; all four codes are legal
    function automatic logic [5:0] data_output_clock_ratio_of(input logic [1:0] code);
        unique case (code)
            2'h0: data_output_clock_ratio_of = DATA_OUTPUT_CLOCK_RATIO_1;
            2'h1: data_output_clock_ratio_of = DATA_OUTPUT_CLOCK_RATIO_2;
            2'h2: data_output_clock_ratio_of = DATA_OUTPUT_CLOCK_RATIO_4;
            2'h3: data_output_clock_ratio_of = DATA_OUTPUT_CLOCK_RATIO_8;
        endcase
    endfunction

    function automatic logic [7:0] read_word(input logic [7:0] addr, input logic [7:0] power_reg,
                                             input logic [7:0] data_output_clock_reg, input logic [7:0] status);
        unique case (addr)
            POWER_AND_MODULATOR_CLOCK_CONTROL_OFFSET: read_word = power_reg;
            DATA_CLOCK_CONTROL_OFFSET:                read_word = data_output_clock_reg;
            CLOCK_TREE_STATUS_OFFSET:                 read_word = status;
            default:                                  read_word = 8'h00;
        endcase
    endfunction

    // Pin inputs, two flops each
    logic [3:0] strap_meta;
    logic [3:0] strap_sync;
    logic [1:0] source_meta;
    logic [1:0] source_sync;
    logic       serial_meta;
    logic       serial_sync;
    logic       source_caught;
    // Fill flags ride with the pin samples so the source is never caught from reset zeros
    logic       fill_meta;
    logic       fill_sync;

    logic [7:0] power_and_modulator_clock_control;
    logic [7:0] data_clock_control;
    clk_source_e clk_source;

    wire logic        wr_power   = i_reg_req.wr && (i_reg_req.addr == POWER_AND_MODULATOR_CLOCK_CONTROL_OFFSET);
    wire logic        wr_data_output_clock    = i_reg_req.wr && (i_reg_req.addr == DATA_CLOCK_CONTROL_OFFSET);
    wire power_mode_e reg_power  = power_mode_e'(power_and_modulator_clock_control[POWER_MODE_LSB +: 2]);
    wire mod_div_e    reg_div    = mod_div_e'(power_and_modulator_clock_control[MOD_DIV_LSB +: 2]);
    wire power_mode_e strap_pwr  = strap_power(strap_sync[STRAP_POWER_LSB +: 2]);
    wire clk_source_e strap_source = (source_sync == SRC_RSVD) ? SRC_CMOS : clk_source_e'(source_sync);
    wire logic [1:0]  strap_data_output_clock = strap_sync[STRAP_DATA_CLOCK_DIVIDER_LSB +: 2];

    // Independent choice under serial control, tracking choice under straps
    wire power_mode_e eff_power  = serial_sync ? reg_power : strap_pwr;
    wire mod_div_e    eff_div    = serial_sync ? reg_div : div_for_power(strap_pwr);
    wire logic [1:0]  eff_data_output_clock   = serial_sync ? data_clock_control[DATA_CLOCK_DIVIDER_LSB +: 2]
                                              : strap_data_output_clock;
    wire logic [5:0]  data_output_clock_ratio = data_output_clock_ratio_of(eff_data_output_clock);

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            strap_meta <= 4'h0;
            strap_sync <= 4'h0;
        end else begin
            strap_meta <= i_mode_strap_pins;
            strap_sync <= strap_meta;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            source_meta <= 2'h0;
            source_sync <= 2'h0;
            fill_meta   <= 1'b0;
            fill_sync   <= 1'b0;
        end else begin
            source_meta <= i_clk_source_strap;
            source_sync <= source_meta;
            fill_meta   <= 1'b1;
            fill_sync   <= fill_meta;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            serial_meta <= 1'b0;
            serial_sync <= 1'b0;
        end else begin
            serial_meta <= i_serial_control;
            serial_sync <= serial_meta;
        end
    end

    // Source strap caught once after reset; one source only, reserved code falls back to logic clock
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            source_caught <= 1'b0;
            clk_source    <= SRC_CMOS;
        end else if (!source_caught && fill_sync) begin
            source_caught <= 1'b1;
            clk_source    <= strap_source;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            power_and_modulator_clock_control <= POWER_AND_MODULATOR_CLOCK_CONTROL_RESET;
            data_clock_control                <= DATA_CLOCK_CONTROL_RESET;
        end else begin
            if (wr_power) begin
                power_and_modulator_clock_control <= i_reg_req.wdata;
            end
            if (wr_data_output_clock) begin
                data_clock_control <= i_reg_req.wdata;
            end
        end
    end

    // One divider pair for all channels: no per-channel setting exists
    logic mod_tick;
    logic mod_half;
    logic mod_level;
    logic data_output_clock_tick;
    logic data_output_clock_level;

    glitchless_divider u_mod_div (
        .i_core_clk  (i_core_clk),
        .i_rst_n     (i_rst_n),
        .i_ratio     (mod_ratio(eff_div)),
        .o_tick      (mod_tick),
        .o_half_tick (mod_half),
        .o_level     (mod_level)
    );

    glitchless_divider u_data_clock_divider (
        .i_core_clk  (i_core_clk),
        .i_rst_n     (i_rst_n),
        .i_ratio     (data_output_clock_ratio),
        .o_tick      (data_output_clock_tick),
        .o_half_tick (),
        .o_level     (data_output_clock_level)
    );

    // Data output clock runs free of any transfer; lane sizing is left to the integrator
    always_comb begin
        o_clocks.mod_clk                = mod_level;
        o_clocks.mod_clk_rise           = mod_tick;
        o_clocks.sample_en              = mod_tick | mod_half;
        o_clocks.data_output_clock      = data_output_clock_level;
        o_clocks.data_output_clock_rise = data_output_clock_tick;
    end

    wire logic [7:0]     status_word   = {clk_source, 2'h0, eff_power, eff_div};
    // Unmapped offsets read as zero so a host probe never sees stale data
    wire logic [7:0]     read_mux      = read_word(i_reg_req.addr, power_and_modulator_clock_control,
                                                   data_clock_control, status_word);
    wire clock_setting_s eff_setting   = '{power_mode: eff_power, mod_div: eff_div, data_clock_divider: eff_data_output_clock};
    wire logic [2:0]     source_onehot = 3'h1 << clk_source;

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_reg_rdata         <= 8'h00;
            o_setting           <= '0;
            o_clk_source        <= SRC_CMOS;
            o_clk_source_onehot <= 3'h1;
        end else begin
            o_reg_rdata         <= read_mux;
            o_setting           <= eff_setting;
            o_clk_source        <= clk_source;
            o_clk_source_onehot <= source_onehot;
        end
    end
endmodule

// ### tb/adc_clock_tree_asserts.sv
// Checker: port level timing relations of the clock tree
`timescale 1ns/100ps
module adc_clock_tree_asserts
    import adc_clock_tree_pkg::*;
(
    input wire logic                           i_core_clk,
    input wire logic                           i_rst_n,
    input wire logic                           i_serial_control,
    input wire adc_clock_tree_pkg::reg_req_s   i_reg_req,
    input wire logic [7:0]                     o_reg_rdata,
    input wire adc_clock_tree_pkg::clock_setting_s o_setting,
    input wire adc_clock_tree_pkg::clk_source_e    o_clk_source,
    input wire logic [2:0]                     o_clk_source_onehot,
    input wire adc_clock_tree_pkg::clock_out_s     o_clocks
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // Shortest ratio is 4, so three quiet cycles follow every rise
    sequence s_mod_quiet;
        !o_clocks.mod_clk_rise [*3];
    endsequence
    sequence s_strap_held;
        !i_serial_control [*6];
    endsequence
    a_rise_level: assert property (o_clocks.mod_clk_rise |=> o_clocks.mod_clk)
        else $error("modulator level low after rise");
    a_mod_min: assert property (o_clocks.mod_clk_rise |=> s_mod_quiet)
        else $error("modulator period shorter than 4");
    a_mod_max: assert property (o_clocks.mod_clk_rise |-> ##[4:32] o_clocks.mod_clk_rise)
        else $error("modulator period longer than 32");
    a_sample_edge: assert property (o_clocks.mod_clk_rise |-> o_clocks.sample_en)
        else $error("no sample at modulator period start");
    a_sample_mid: assert property ($fell(o_clocks.mod_clk) |-> $past(o_clocks.sample_en))
        else $error("no sample at modulator mid period");
    a_data_output_clock_level: assert property (o_clocks.data_output_clock_rise |=> o_clocks.data_output_clock)
        else $error("data output clock level low after rise");
    a_data_output_clock_cont: assert property (o_clocks.data_output_clock_rise |-> ##[1:8] o_clocks.data_output_clock_rise)
        else $error("data output clock stopped");
    a_src_onehot: assert property (o_clk_source != SRC_RSVD && o_clk_source_onehot == (3'h1 << o_clk_source))
        else $error("clock source not a single choice");
    a_strap_tie: assert property (s_strap_held |-> o_setting.mod_div == mod_div_e'(o_setting.power_mode))
        else $error("strap divider not tied to power mode");
    a_unmapped_zero: assert property (!(i_reg_req.addr inside {8'h04, 8'h07, 8'h08}) |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule

// ### tb/serial_host_model.sv
// Host side model: register writes and reads on the internal port
`timescale 1ns/100ps
module serial_host_model
    import adc_clock_tree_pkg::*;
(
    input  wire logic                         i_core_clk,
    input  wire logic [7:0]                   i_rdata,
    output adc_clock_tree_pkg::reg_req_s      o_req
);
    initial o_req = '0;
    // Driven at falling edge so the design samples a settled request
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        o_req = '{1'b1, a, d};
        @(negedge i_core_clk);
        o_req.wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_core_clk);
        o_req = '{1'b0, a, 8'h00};
        @(negedge i_core_clk);
        d = i_rdata;
    endtask
endmodule

// ### tb/tb_adc_clock_tree_power_scaling.sv
// Testbench: registers, straps and divided clock periods
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_adc_clock_tree_power_scaling;
    import adc_clock_tree_pkg::*;
    logic clk = 0, rst_n = 0, sc = 1;
    logic [3:0] pins = 4'h0;
    logic [1:0] src = 2'h0;
    reg_req_s req;
    logic [7:0] rdata, d;
    clock_setting_s set;
    clk_source_e cs;
    logic [2:0] oh;
    clock_out_s co;
    int mismatches = 0, n_checks = 0, n, ep;
    wire logic [1:0] rises = {co.data_output_clock_rise, co.mod_clk_rise};
    always #5 clk = ~clk;
    adc_clock_tree_power_scaling u_adc_clock_tree_power_scaling (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_serial_control(sc), .i_mode_strap_pins(pins), .i_clk_source_strap(src), .i_reg_req(req),
        .o_reg_rdata(rdata), .o_setting(set), .o_clk_source(cs), .o_clk_source_onehot(oh), .o_clocks(co));
    serial_host_model u_serial_host_model (.i_core_clk(clk), .i_rdata(rdata), .o_req(req));
    function int mr(int k);
        return k == 1 ? 8 : k == 2 ? 4 : 32;
    endfunction
    task rst(input logic [1:0] s);
        src = s;
        rst_n = 0;
        repeat (5) @(negedge clk);
        rst_n = 1;
    endtask
    // Counts falling edges between two rise pulses of the chosen clock
    task meas(input int k, output int c);
        int i;
        i = 0;
        c = 0;
        @(negedge clk);
        while (rises[k] !== 1'b1 && i < 100) begin
            @(negedge clk);
            i++;
        end
        do begin
            @(negedge clk);
            c++;
        end while (rises[k] !== 1'b1 && c < 100);
    endtask
    task complete_run;
        if (mismatches == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #200000;
        mismatches++;
        complete_run();
    end
    initial begin
        for (int s = 0; s < 4; s++) begin
            rst(2'(s));
            repeat (5) @(negedge clk);
            `CHK("source", 2'(s == 3 ? 0 : s), cs)
            `CHK("onehot", 3'h1 << (s == 3 ? 0 : s), oh)
        end
        u_serial_host_model.rd(8'h04, d);
        `CHK("reg04 reset", 8'h00, d)
        u_serial_host_model.rd(8'h07, d);
        `CHK("reg07 reset", 8'h00, d)
        u_serial_host_model.wr(8'h10, 8'hFF);
        u_serial_host_model.rd(8'h10, d);
        `CHK("unmapped", 8'h00, d)
        for (int p = 0; p < 4; p++) begin
            for (int m = 0; m < 4; m++) begin
                u_serial_host_model.wr(8'h04, {2'h0, 2'(p), 2'h0, 2'(m)});
                u_serial_host_model.rd(8'h04, d);
                `CHK("reg04", {2'h0, 2'(p), 2'h0, 2'(m)}, d)
                repeat (40) @(negedge clk);
                `CHK("power", 2'(p), set.power_mode)
                `CHK("mod div", 2'(m), set.mod_div)
                meas(0, n);
                `CHK("mod period", mr(m), n)
            end
        end
        for (int c = 0; c < 4; c++) begin
            u_serial_host_model.wr(8'h07, 8'(c));
            u_serial_host_model.rd(8'h07, d);
            `CHK("reg07", 8'(c), d)
            repeat (40) @(negedge clk);
            meas(1, n);
            `CHK("data_output_clock period", 1 << c, n)
            `CHK("data_output_clock code", 2'(c), set.data_clock_divider)
        end
        // Register asks median /32; straps must win while in control
        u_serial_host_model.wr(8'h04, 8'h10);
        sc = 0;
        for (int p = 0; p < 4; p++) begin
            pins = {2'(p), 2'(p)}; // Straps keep the modulator rate matched to the mode
            ep = p == 3 ? 2 : p;
            repeat (40) @(negedge clk);
            `CHK("strap power", 2'(ep), set.power_mode)
            `CHK("strap div", 2'(ep), set.mod_div)
            meas(0, n);
            `CHK("strap mod period", mr(ep), n)
            meas(1, n);
            `CHK("strap data_output_clock period", 1 << p, n)
            `CHK("strap data_output_clock code", 2'(p), set.data_clock_divider)
            u_serial_host_model.rd(8'h08, d);
            `CHK("status", {4'h0, 2'(ep), 2'(ep)}, d)
        end
        sc = 1;
        repeat (40) @(negedge clk);
        `CHK("serial power", 2'h1, set.power_mode)
        `CHK("serial div", 2'h0, set.mod_div)
        complete_run();
    end
endmodule
bind adc_clock_tree_power_scaling adc_clock_tree_asserts u_adc_clock_tree_asserts (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_serial_control(i_serial_control), .i_reg_req(i_reg_req), .o_reg_rdata(o_reg_rdata),
    .o_setting(o_setting), .o_clk_source(o_clk_source), .o_clk_source_onehot(o_clk_source_onehot),
    .o_clocks(o_clocks));
